// File: verilog/clk_select_defines.svh
// timing constants and reset values for the clock source selector
`ifndef CLK_SELECT_DEFINES_SVH
`define CLK_SELECT_DEFINES_SVH

// system clock rate in kHz
`define SYS_CLK_KHZ 100000
// nominal internal oscillator rate in kHz
`define INT_OSC_KHZ 12000
// phase accumulator width of the internal oscillator model
`define PHASE_WIDTH 16
// trim increment that gives the nominal rate from the system clock
`define TRIM_DEFAULT (`INT_OSC_KHZ * 65536 / `SYS_CLK_KHZ)
// internal clocks without an external edge before fallback
`define MISS_LIMIT 32
// width of the missing-edge counter
`define MISS_WIDTH 6

`endif

// File: verilog/clk_select_pkg.sv
// state types for the clock source selector
package clk_select_pkg;

    typedef struct packed {
        logic [2:0] extSync;
        logic extLevel;
        logic useExt;
        logic [5:0] missCount;
        logic [15:0] phase;
        logic [15:0] trim;
        logic clkTick;
        logic switchGap;
    } sel_state_t;

endpackage

// File: verilog/tick_divider.sv
// divides the selected clock tick stream by a programmable ratio
module tick_divider #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic tickIn,
    input wire logic [WIDTH-1:0] divisor,
    output logic tickOut
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic pulse;
    } div_state_t;

    div_state_t st_reg;
    div_state_t st_next;

    // count source ticks, fire once every divisor ticks
    always_comb begin
        st_next = st_reg;
        st_next.pulse = 1'b0;
        if (tickIn) begin
            if (st_reg.count + WIDTH'(1) >= divisor) begin
                st_next.count = '0;
                st_next.pulse = 1'b1;
            end else begin
                st_next.count = st_reg.count + WIDTH'(1);
            end
        end
    end

    // state register with clock enable
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

    assign tickOut = st_reg.pulse;

endmodule

// File: verilog/clock_source_select_failover.sv
// clock source selection with failover to the internal oscillator
//
// Behaviour
// - run from the internal oscillator until the first external rising edge, then use the external clock.
// - on the external clock, 32 internal clocks without an external edge revert to the internal oscillator.
// - the internal oscillator runs at a nominal 12MHz with its trim from factory calibration.
// - chopper, blank time, standstill delay and step rate all derive from the selected clock.
`include "clk_select_defines.svh"

module clock_source_select_failover
    import clk_select_pkg::*;
#(
    parameter int CHOP_W = 8,
    parameter int BLANK_W = 8,
    parameter int STBY_W = 24,
    parameter int STEP_W = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic extClkPin,
    input wire logic [15:0] otpTrim,
    input wire logic [CHOP_W-1:0] chopDivisor,
    input wire logic [BLANK_W-1:0] blankDivisor,
    input wire logic [STBY_W-1:0] standbyDivisor,
    input wire logic [STEP_W-1:0] stepDivisor,
    output logic clkTick,
    output logic extSelected,
    output logic chopTick,
    output logic blankTick,
    output logic standbyTick,
    output logic stepTick
);
    localparam logic [15:0] TRIM_RESET = 16'(`TRIM_DEFAULT);
    localparam logic [5:0] MISS_LAST = 6'(`MISS_LIMIT - 1);

    sel_state_t st_reg;
    sel_state_t st_next;
    logic [16:0] phaseSum;
    logic intTick;
    logic extEdge;

    // internal oscillator model: phase accumulator carry is one tick
    assign phaseSum = {1'b0, st_reg.phase} + {1'b0, st_reg.trim};
    assign intTick = phaseSum[16];

    // accepted external rise: second and third stage agree high
    assign extEdge = st_reg.extSync[1] & st_reg.extSync[2] & ~st_reg.extLevel;

    // next-state logic
    always_comb begin
        st_next = st_reg;
        st_next.extSync = {st_reg.extSync[1:0], extClkPin};
        if (st_reg.extSync[1] == st_reg.extSync[2]) begin
            st_next.extLevel = st_reg.extSync[2];
        end
        st_next.phase = phaseSum[15:0];
        st_next.trim = otpTrim;
        st_next.switchGap = 1'b0;
        st_next.clkTick = 1'b0;
        if (!st_reg.useExt) begin
            if (extEdge) begin
                // take the external source, skip this edge
                st_next.useExt = 1'b1;
                st_next.missCount = '0;
                st_next.switchGap = 1'b1;
            end else begin
                st_next.clkTick = intTick;
            end
        end else begin
            if (extEdge) begin
                st_next.missCount = '0;
                st_next.clkTick = 1'b1;
            end else if (intTick) begin
                if (st_reg.missCount == MISS_LAST) begin
                    // external clock lost: fall back
                    st_next.useExt = 1'b0;
                    st_next.missCount = '0;
                    st_next.switchGap = 1'b1;
                end else begin
                    st_next.missCount = st_reg.missCount + 6'h01;
                end
            end
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.trim <= TRIM_RESET;
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

    assign clkTick = st_reg.clkTick;
    assign extSelected = st_reg.useExt;

    // timing generators driven by the selected tick
    tick_divider #(.WIDTH(CHOP_W)) chopDiv (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .tickIn(st_reg.clkTick),
        .divisor(chopDivisor),
        .tickOut(chopTick)
    );
    tick_divider #(.WIDTH(BLANK_W)) blankDiv (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .tickIn(st_reg.clkTick),
        .divisor(blankDivisor),
        .tickOut(blankTick)
    );
    tick_divider #(.WIDTH(STBY_W)) standbyDiv (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .tickIn(st_reg.clkTick),
        .divisor(standbyDivisor),
        .tickOut(standbyTick)
    );
    tick_divider #(.WIDTH(STEP_W)) stepDiv (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .tickIn(st_reg.clkTick),
        .divisor(stepDivisor),
        .tickOut(stepTick)
    );

    // checks on selection and failover
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_edge_selects_ext: assert property (
        clkEn && !st_reg.useExt && extEdge |=> st_reg.useExt
    ) else $error("external edge did not select external clock");

    a_no_edge_stay_int: assert property (
        clkEn && !st_reg.useExt && !extEdge |=> !st_reg.useExt
    ) else $error("external clock selected without an edge");

    a_miss_fallback: assert property (
        clkEn && st_reg.useExt && !extEdge && intTick
        && st_reg.missCount == 6'h1f |=> !st_reg.useExt
    ) else $error("no fallback after 32 missing internal clocks");

    a_miss_bounded: assert property (
        st_reg.missCount <= 6'h1f
    ) else $error("missing-edge count passed its limit");

    a_edge_clears_miss: assert property (
        clkEn && st_reg.useExt && extEdge |=> st_reg.missCount == 6'h00
        && st_reg.clkTick
    ) else $error("external edge did not clear miss count");

    a_trim_follows: assert property (
        clkEn |=> st_reg.trim == $past(otpTrim)
    ) else $error("trim value not taken from calibration input");

    a_switch_no_tick: assert property (
        clkEn && $changed(st_reg.useExt) |-> !st_reg.clkTick
        && st_reg.switchGap
    ) else $error("tick emitted on a source switch");

    a_int_tick_source: assert property (
        clkEn && !st_reg.useExt && intTick && !extEdge |=> st_reg.clkTick
    ) else $error("internal tick not passed to timing logic");

    // no stray ticks between source events
    a_int_idle_quiet: assert property (
        clkEn && !st_reg.useExt && !intTick && !extEdge |=> !st_reg.clkTick
    ) else $error("tick without an internal carry");

    a_ext_idle_quiet: assert property (
        clkEn && st_reg.useExt && !extEdge |=> !st_reg.clkTick
    ) else $error("tick on external source without an edge");

    // synchroniser shifts one stage per enabled cycle
    a_sync_shift: assert property (
        clkEn |=> st_reg.extSync[2] == $past(st_reg.extSync[1])
    ) else $error("synchroniser stage did not shift");

    // missing-edge counter steps once per internal carry
    a_miss_count_up: assert property (
        clkEn && st_reg.useExt && !extEdge && intTick
        && st_reg.missCount != 6'h1f
        |=> st_reg.missCount == $past(st_reg.missCount) + 6'h01
    ) else $error("miss count did not advance on internal tick");

    a_miss_hold: assert property (
        clkEn && st_reg.useExt && !extEdge && !intTick
        |=> $stable(st_reg.missCount)
    ) else $error("miss count moved without internal tick");

    a_fallback_clears: assert property (
        clkEn && st_reg.useExt && !extEdge && intTick
        && st_reg.missCount == 6'h1f
        |=> st_reg.missCount == 6'h00 && !st_reg.clkTick
    ) else $error("fallback left count or emitted a tick");

    // every timing pulse follows a selected tick
    a_chop_after_tick: assert property (
        clkEn && chopTick |-> $past(st_reg.clkTick)
    ) else $error("chopper pulse without a selected tick");

    a_blank_after_tick: assert property (
        clkEn && blankTick |-> $past(st_reg.clkTick)
    ) else $error("blank pulse without a selected tick");

    a_standby_after_tick: assert property (
        clkEn && standbyTick |-> $past(st_reg.clkTick)
    ) else $error("standstill pulse without a selected tick");

    a_step_after_tick: assert property (
        clkEn && stepTick |-> $past(st_reg.clkTick)
    ) else $error("step pulse without a selected tick");

endmodule

// File: test/ext_clk_model.sv
// external oscillator model driving the clock pin
module ext_clk_model (
    input wire logic sys_clk,
    input wire logic run,
    input wire logic [4:0] half,
    output logic extClkPin
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial extClkPin = 1'b0;
    // toggles every half sys_clk cycles, held low when stopped
    always @(negedge sys_clk) begin
        if (!run) begin
            extClkPin <= 1'b0;
            cnt <= 0;
        end else if (cnt >= int'(half) - 1) begin
            extClkPin <= ~extClkPin;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// File: test/tb_top.sv
// self-checking bench for the clock source selector
`include "clk_select_defines.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst_n = 0, run = 0, selSeen = 0;
    logic [4:0] half = 5'h04;
    logic [15:0] lfsr = 16'h0027, otpTrim = `TRIM_DEFAULT, stepDiv = 16'h0001;
    logic [7:0] chopDiv = 8'h01, blankDiv = 8'h01;
    logic [23:0] stbyDiv = 24'h000001;
    logic extClkPin, clkTick, extSelected, chopTick;
    logic blankTick, standbyTick, stepTick;
    logic expQ[$];
    int fails = 0, n_compared = 0, nClk, nChop, c, h, k;
    int nBlank, nStby, nStep;
    int hs[2] = '{4, 12};
    always #5 sys_clk = ~sys_clk;
    ext_clk_model u_ext_clk_model (.sys_clk(sys_clk), .run(run),
        .half(half), .extClkPin(extClkPin));
    clock_source_select_failover u_clock_source_select_failover (
        .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(1'b1),
        .extClkPin(extClkPin), .otpTrim(otpTrim), .chopDivisor(chopDiv),
        .blankDivisor(blankDiv), .standbyDivisor(stbyDiv),
        .stepDivisor(stepDiv), .clkTick(clkTick),
        .extSelected(extSelected), .chopTick(chopTick),
        .blankTick(blankTick), .standbyTick(standbyTick),
        .stepTick(stepTick));
    task automatic checkBit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic checkNear(input int got, input int exp, input int tol);
        n_compared++;
        if (got < exp - tol || got > exp + tol) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // fresh random divisors from the lfsr
    task automatic newDivisors();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        chopDiv = 8'h01 + 8'(lfsr[2:0]);
        blankDiv = lfsr[15:8];
        stbyDiv = 24'(lfsr[11:4]);
        stepDiv = lfsr;
    endtask
    // counts ticks over n cycles, then compares them
    task automatic window(input int n, input int exp);
        @(negedge sys_clk);
        nClk = 0;
        nChop = 0;
        nBlank = 0;
        nStby = 0;
        nStep = 0;
        repeat (n) @(negedge sys_clk);
        checkNear(nClk, exp, 2);
        checkNear(nChop, nClk / int'(chopDiv), 1);
        checkNear(nBlank, nClk / (blankDiv == 0 ? 1 : int'(blankDiv)), 1);
        checkNear(nStby, nClk / (stbyDiv == 0 ? 1 : int'(stbyDiv)), 1);
        checkNear(nStep, nClk / (stepDiv == 0 ? 1 : int'(stepDiv)), 1);
    endtask
    // monitor: tick counts and source changes against the queue
    always @(negedge sys_clk) begin
        if (rst_n) begin
            nClk += (clkTick === 1'b1) ? 1 : 0;
            nChop += (chopTick === 1'b1) ? 1 : 0;
            nBlank += (blankTick === 1'b1) ? 1 : 0;
            nStby += (standbyTick === 1'b1) ? 1 : 0;
            nStep += (stepTick === 1'b1) ? 1 : 0;
            if (extSelected !== selSeen) begin
                selSeen = extSelected;
                checkBit(clkTick, 1'b0);
                if (expQ.size() == 0) checkBit(extSelected, ~extSelected);
                else checkBit(extSelected, expQ.pop_front());
            end
        end
    end
    initial begin
        #200000;
        fails++;
        results();
    end
    initial begin
        newDivisors();
        repeat (2) @(negedge sys_clk);
        rst_n = 1;
        window(2000, 2000 * `TRIM_DEFAULT / 65536);
        for (int i = 0; i < 2; i++) begin
            newDivisors();
            half = 5'(hs[i]);
            expQ.push_back(1'b1);
            run = 1;
            k = 0;
            while (extSelected !== 1'b1 && k < 40) begin
                @(negedge sys_clk);
                k++;
            end
            checkNear(k, hs[i] + 4, 2);
            window(2000, 1000 / hs[i]);
            expQ.push_back(1'b0);
            run = 0;
            k = 0;
            while (extSelected !== 1'b0 && k < 400) begin
                @(negedge sys_clk);
                k++;
            end
            checkNear(k, 32 * 65536 / `TRIM_DEFAULT, 30);
            window(1000, 1000 * `TRIM_DEFAULT / 65536);
        end
        repeat (3) @(negedge sys_clk);
        checkNear(expQ.size(), 0, 0);
        results();
    end
endmodule
